// *** dv/idalu_checker.sv ***
// Port-level assertions for the inc/dec/decimal-adjust slice
`timescale 1ns/10ps
`default_nettype none
module idalu_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Operand memory and completion
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic done
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================
  // Bus answers: no wait states, holes refused
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  unmapped_err_a: assert property (psel && !penable && (paddr == 8'h28 || paddr == 8'h38)
    |=> pready && pslverr) else $error("hole not refused");
  // ==========================================
  // Memory sequence: read four states, write two later, done two after
  read_len_a: assert property ($rose(mem_rd) |-> mem_rd [*4] ##1 !mem_rd)
    else $error("read cycle length wrong");
  rd_then_wr_a: assert property ($fell(mem_rd) |-> ##1 mem_wr)
    else $error("write does not follow read");
  same_addr_a: assert property (mem_wr |-> $past(mem_rd, 2) && mem_addr == $past(mem_addr, 2))
    else $error("write address differs from read");
  single_wr_a: assert property (mem_wr |=> !mem_wr [*3])
    else $error("extra write");
  wr_to_done_a: assert property (mem_wr |-> ##2 done)
    else $error("completion late after write");
  no_overlap_a: assert property (!(mem_rd && mem_wr))
    else $error("read and write together");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  // Main scenarios reached
  cover property ($fell(mem_rd) ##1 mem_wr);
  cover property (pready && pslverr);
  cover property (done && !mem_wr);
endmodule : idalu_checker
bind idalu_core idalu_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd),
  .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .done(done));
`default_nettype wire

// *** dv/idalu_core_tb.sv ***
// Self-checking bench for the inc/dec/decimal-adjust slice
`timescale 1ns/10ps
`default_nettype none
module idalu_core_tb;
  import idalu_pkg::*;
  typedef struct {logic [23:0] insn; logic [2:0] r; logic [15:0] ad;
    logic [7:0] op; logic [7:0] fi; logic [7:0] res; logic [7:0] fo;} idalu_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_rd, mem_wr, done;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata;
  logic [15:0] mem_addr;
  logic [7:0] mem [0:65535];
  int err_total, total_checks, n;
  // Opcode, register, address, operand, flags in, result, flags out
  idalu_row_s rows [17] = '{
    '{24'h000004, 3'h0, 16'h0000, 8'h7F, 8'h01, 8'h80, 8'h95},
    '{24'h00003D, 3'h7, 16'h0000, 8'h80, 8'h00, 8'h7F, 8'h16},
    '{24'h00001D, 3'h3, 16'h0000, 8'h00, 8'h01, 8'hFF, 8'h93},
    '{24'h000027, 3'h7, 16'h0000, 8'h3C, 8'h00, 8'h42, 8'h14},
    '{24'h000027, 3'h7, 16'h0000, 8'hA5, 8'h00, 8'h05, 8'h05},
    '{24'h000027, 3'h7, 16'h0000, 8'h12, 8'h00, 8'h12, 8'h04},
    '{24'h000027, 3'h7, 16'h0000, 8'h32, 8'h10, 8'h38, 8'h00},
    '{24'h000027, 3'h7, 16'h0000, 8'h2B, 8'h01, 8'h91, 8'h91},
    '{24'h000027, 3'h7, 16'h0000, 8'h2F, 8'h12, 8'h29, 8'h02},
    '{24'h000027, 3'h7, 16'h0000, 8'h90, 8'h03, 8'h30, 8'h07},
    '{24'h000027, 3'h7, 16'h0000, 8'h66, 8'h13, 8'h00, 8'h47},
    '{24'h000034, 3'h6, 16'h1234, 8'hFF, 8'h00, 8'h00, 8'h50},
    '{24'h000035, 3'h6, 16'h1234, 8'h01, 8'h01, 8'h00, 8'h43},
    '{24'h1034DD, 3'h6, 16'h2030, 8'h34, 8'h00, 8'h35, 8'h00},
    '{24'h0534FD, 3'h6, 16'h2005, 8'h7F, 8'h00, 8'h80, 8'h94},
    '{24'hF035FD, 3'h6, 16'h1FF0, 8'h80, 8'h00, 8'h7F, 8'h16},
    '{24'h8035DD, 3'h6, 16'h1FA0, 8'h01, 8'h00, 8'h00, 8'h42}};

  idalu_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .done(done));

  // ==========================================
  // Clock, and byte memory that shows junk while not read
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end

  // ==========================================
  // Shared compare, bus cycle and wait helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold the request until ready is seen at an edge; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    chk({31'h0, e}, {31'h0, ee});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
    input logic ee);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q & m, x);
    chk({31'h0, e}, {31'h0, ee});
  endtask : rd
  task automatic wait_done(output int c);
    c = 0;
    do begin
      @(posedge pclk);
      #1;
      c++;
    end while (done !== 1'b1 && c < 40);
  endtask : wait_done
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    chk({28'h0, done, mem_rd, mem_wr, pready}, 32'h0);
    presetn <= 1'b1;
    rd(OFS_STAT, 32'h0, 32'hFFFFFFFF, 1'b0);
    rd(OFS_FLAG, {24'h0, FLG_RST}, 32'hFFFFFFFF, 1'b0);
    rd(OFS_IDX1, {16'h0, IDX_RST}, 32'hFFFFFFFF, 1'b0);
  endtask : do_reset
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  // ==========================================
  // One instruction from a row: load, start, time, compare
  task automatic run(input idalu_row_s t);
    logic [4:0] ts;
    logic [2:0] ms;
    ts = (t.r != FLD_MEM) ? 5'h04 : ((t.insn[15:8] == 8'h00) ? 5'h0B : 5'h17);
    ms = (t.r != FLD_MEM) ? 3'h1 : ((t.insn[15:8] == 8'h00) ? 3'h3 : 3'h6);
    if (t.r == FLD_MEM) mem[t.ad] = t.op;
    else wr(OFS_GPR + {3'h0, t.r, 2'h0}, {24'h0, t.op}, 1'b0);
    wr(OFS_FLAG, {24'h0, t.fi}, 1'b0);
    wr(OFS_INSN, {8'h0, t.insn}, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    wait_done(n);
    chk(32'(n), {27'h0, ts});
    if (t.r == FLD_MEM) chk({24'h0, mem[t.ad]}, {24'h0, t.res});
    else rd(OFS_GPR + {3'h0, t.r, 2'h0}, {24'h0, t.res}, 32'hFF, 1'b0);
    rd(OFS_FLAG, {24'h0, t.fo}, 32'hD7, 1'b0);
    rd(OFS_STAT, {13'h0, ms, 3'h0, ts, 8'h0}, 32'hFFFFFFFF, 1'b0);
  endtask : run

  // ==========================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    err_total = 0;
    total_checks = 0;
    do_reset();
    $display("reset test done");
    wr(OFS_GPR + 8'h10, 32'h12, 1'b0);
    wr(OFS_GPR + 8'h14, 32'h34, 1'b0);
    wr(OFS_IDX1, 32'h2020, 1'b0);
    wr(OFS_IDX2, 32'h2000, 1'b0);
    foreach (rows[i]) run(rows[i]);
    $display("row tests done");
    // Holes, status write and a write during a memory instruction are refused
    rd(8'h28, 32'h0, 32'hFFFFFFFF, 1'b1);
    rd(8'h38, 32'h0, 32'hFFFFFFFF, 1'b1);
    wr(OFS_STAT, 32'h3, 1'b1);
    wr(OFS_INSN, 32'h34, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    wr(OFS_INSN, 32'h35, 1'b1);
    wait_done(n);
    chk({24'h0, mem[16'h1234]}, 32'h01);
    // An undecodable first byte raises illegal, cleared by control bit 1
    wr(OFS_INSN, 32'h0, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    rd(OFS_STAT, 32'h2, 32'h3, 1'b0);
    wr(OFS_CTRL, 32'h2, 1'b0);
    rd(OFS_STAT, 32'h0, 32'h3, 1'b0);
    $display("refusal tests done");
    // Reset in mid-instruction leaves the operand untouched
    wr(OFS_INSN, 32'h1034DD, 1'b0);
    wr(OFS_CTRL, 32'h1, 1'b0);
    repeat (6) @(posedge pclk);
    do_reset();
    chk({24'h0, mem[16'h2030]}, 32'h35);
    $display("mid-run reset test done");
    tally_and_finish();
  end
  // Watchdog well beyond the expected run of about six hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_total++;
    tally_and_finish();
  end
endmodule : idalu_core_tb
`default_nettype wire

// *** logic/idalu_alu_if.sv ***
// Interface between the sequencer and the arithmetic unit
`timescale 1ns/10ps
`default_nettype none
interface idalu_alu_if;
  import idalu_pkg::*;
  idalu_op_e op;
  logic [7:0] opnd;
  logic [7:0] flg_in;
  logic [7:0] res;
  logic [7:0] flg_out;
  modport core (output op, output opnd, output flg_in, input res, input flg_out);
  modport unit (input op, input opnd, input flg_in, output res, output flg_out);
endinterface : idalu_alu_if
`default_nettype wire

// *** logic/idalu_core.sv ***
// Inc/dec/decimal-adjust slice with APB register access and memory port
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - DD 34 d increments the byte at first index plus displacement.
// - FD 34 d increments the byte at second index plus displacement.
// - Indexed address is 16-bit index plus sign-extended displacement.
// - Indexed inc/dec take 6 M cycles, 23 states: 4,4,3,5,4,3.
// - Increment: H from bit-3 carry, PV if operand 7F, N cleared, C kept.
// - Inc/dec set S for negative result and Z for zero result.
// - Decrement decodes as 00rrr101, 35, or DD/FD 35 d.
// - Register field: B0 C1 D2 E3 H4 L5 A7.
// - Decrement: H on bit-4 borrow, PV if operand 80, N set, C kept.
// - Register decrement 1 M cycle of 4; pointer memory 3 M cycles, 11 states.
// - Adjust after add adds 00, 06, 60 or 66 by flags and nibbles.
// - Adjust after subtract adds 00, FA, A0 or 9A likewise.
// - Adjust sets carry exactly when the upper correction applies.
// - Adjust: S from bit 7, Z on zero, PV on even parity, N kept.
module idalu_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operand memory
  output logic [15:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  // Completion
  output logic done
);
  import idalu_pkg::*;

  // ==========================================
  // State
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_EXEC = 4'b0010,
    ST_READ = 4'b0100,
    ST_WRITE = 4'b1000
  } idalu_st_e;

  typedef struct packed {
    idalu_st_e st;
    logic [2:0] mc;
    logic [2:0] tc;
    logic [2:0] mlast;
    logic [4:0] tsum;
    logic is_mem;
    logic is_idx;
    idalu_op_e op;
    logic [2:0] dst;
    logic [7:0] opnd;
    logic [23:0] insn;
    logic [7:0][7:0] gpr;
    logic [7:0] flg;
    logic [15:0] ix1;
    logic [15:0] ix2;
    logic illegal;
    logic [4:0] last_t;
    logic [2:0] last_m;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [15:0] maddr;
    logic mrd;
    logic mwr;
    logic [7:0] mwdata;
    logic done;
  } idalu_core_s;

  idalu_core_s q;
  idalu_core_s n;

  idalu_alu_if alu_if ();

  // ==========================================
  // Helpers
  // States in a given machine cycle of the current form
  function automatic logic [2:0] mc_len(input logic idx, input logic mem,
                                        input logic [2:0] mc);
    if (idx) begin
      mc_len = IDX_TS[mc];
    end else if (mem) begin
      mc_len = PTR_TS[mc[1:0]];
    end else begin
      mc_len = REG_TS;
    end
  endfunction : mc_len

  // Index plus sign-extended displacement
  function automatic logic [15:0] idx_addr(input logic [15:0] base, input logic [7:0] d);
    idx_addr = base + {{8{d[7]}}, d};
  endfunction : idx_addr

  // ==========================================
  // Arithmetic unit
  idalu_unit u_unit (
    .alu(alu_if.unit)
  );

  assign alu_if.op = q.op;
  assign alu_if.opnd = q.opnd;
  assign alu_if.flg_in = q.flg;

  // ==========================================
  // Next-state logic
  always_comb begin
    logic setup;
    logic acc;
    logic busy;
    logic start;
    logic [2:0] gi;
    logic [7:0] b0;
    logic [7:0] b1;
    logic [7:0] dsp;
    logic [2:0] nmc;
    setup = psel && !penable;
    acc = psel && penable && q.pready;
    busy = (q.st != ST_IDLE);
    start = 1'b0;
    gi = 3'(paddr[4:2] - OFS_GPR[4:2]);
    b0 = q.insn[7:0];
    b1 = q.insn[15:8];
    dsp = q.insn[23:16];
    nmc = 3'(q.mc + 3'h1);
    n = q;
    n.done = 1'b0;
    n.mwr = 1'b0;

    // APB: answer prepared in setup, so access phase completes at once
    if (setup) begin
      n.pready = 1'b1;
      n.pslverr = 1'b0;
      n.prdata = 32'h0000_0000;
      if (paddr == OFS_CTRL) begin
        n.prdata = 32'h0000_0000;
      end else if (paddr == OFS_INSN) begin
        n.prdata = {8'h00, q.insn};
        n.pslverr = pwrite && busy;
      end else if (paddr == OFS_STAT) begin
        n.prdata = {12'h000, 1'b0, q.last_m, 3'h0, q.last_t, 6'h00, q.illegal, busy};
        n.pslverr = pwrite;
      end else if (paddr == OFS_FLAG) begin
        n.prdata = {24'h00_0000, q.flg};
        n.pslverr = pwrite && busy;
      end else if (paddr >= OFS_GPR && paddr <= OFS_GPR_END && paddr[1:0] == 2'h0
                   && gi != FLD_MEM) begin
        n.prdata = {24'h00_0000, q.gpr[gi]};
        n.pslverr = pwrite && busy;
      end else if (paddr == OFS_IDX1) begin
        n.prdata = {16'h0000, q.ix1};
        n.pslverr = pwrite && busy;
      end else if (paddr == OFS_IDX2) begin
        n.prdata = {16'h0000, q.ix2};
        n.pslverr = pwrite && busy;
      end else begin
        // Unmapped: error, reads zero
        n.pslverr = 1'b1;
      end
    end

    // Write takes effect at the completing edge only
    if (acc) begin
      n.pready = 1'b0;
      if (pwrite && !q.pslverr) begin
        if (paddr == OFS_CTRL) begin
          start = pwdata[CTRL_START] && !busy;
          if (pwdata[CTRL_CLR_ILL]) begin
            n.illegal = 1'b0;
          end
        end else if (paddr == OFS_INSN) begin
          n.insn = pwdata[23:0];
        end else if (paddr == OFS_FLAG) begin
          n.flg = pwdata[7:0];
        end else if (paddr == OFS_IDX1) begin
          n.ix1 = pwdata[15:0];
        end else if (paddr == OFS_IDX2) begin
          n.ix2 = pwdata[15:0];
        end else begin
          n.gpr[gi] = pwdata[7:0];
        end
      end
    end

    // Sequencer: one T state per pclk
    unique case (q.st)
      ST_IDLE: begin
        if (start) begin
          n.st = ST_EXEC;
          n.mc = 3'h0;
          n.tc = 3'h0;
          n.tsum = 5'h00;
          n.is_mem = 1'b0;
          n.is_idx = 1'b0;
          n.mlast = REG_MLAST;
          n.dst = b0[5:3];
          n.op = b0[0] ? OP_DEC : OP_INC;
          n.opnd = q.gpr[b0[5:3]];
          if ((b0 == PFX_IDX1 || b0 == PFX_IDX2)
              && (b1 == OPC_INC_MEM || b1 == OPC_DEC_MEM)) begin
            n.is_mem = 1'b1;
            n.is_idx = 1'b1;
            n.mlast = IDX_MLAST;
            n.op = b1[0] ? OP_DEC : OP_INC;
            n.maddr = idx_addr((b0 == PFX_IDX1) ? q.ix1 : q.ix2, dsp);
          end else if (b0 == OPC_INC_MEM || b0 == OPC_DEC_MEM) begin
            n.is_mem = 1'b1;
            n.mlast = PTR_MLAST;
            n.maddr = {q.gpr[FLD_H], q.gpr[FLD_L]};
          end else if (b0 == OPC_DAA) begin
            n.op = OP_DAA;
            n.dst = FLD_ACC;
            n.opnd = q.gpr[FLD_ACC];
          end else if (b0[7:6] == 2'h0 && b0[2:1] == 2'h2 && b0[5:3] != FLD_MEM) begin
            n.op = b0[0] ? OP_DEC : OP_INC;
          end else begin
            // Not an operation of this slice: flag it and stay idle
            n.st = ST_IDLE;
            n.illegal = 1'b1;
          end
        end
      end
      ST_EXEC, ST_READ, ST_WRITE: begin
        n.tc = 3'(q.tc + 3'h1);
        n.tsum = 5'(q.tsum + 5'h01);
        // Data is written on the second state of the write cycle
        if (q.st == ST_WRITE && q.tc == 3'h0) begin
          n.mwr = 1'b1;
          n.mwdata = alu_if.res;
        end
        if (q.tc == 3'(mc_len(q.is_idx, q.is_mem, q.mc) - 3'h1)) begin
          n.tc = 3'h0;
          n.mc = nmc;
          if (q.st == ST_READ) begin
            n.opnd = mem_rdata;
          end
          if (q.mc == q.mlast) begin
            // Instruction done: commit result and flags
            n.st = ST_IDLE;
            n.mc = 3'h0;
            n.done = 1'b1;
            n.flg = alu_if.flg_out;
            n.last_t = 5'(q.tsum + 5'h01);
            n.last_m = 3'(q.mlast + 3'h1);
            if (!q.is_mem) begin
              n.gpr[q.dst] = alu_if.res;
            end
          end else if (q.is_mem && nmc == 3'(q.mlast - 3'h1)) begin
            n.st = ST_READ;
          end else if (q.is_mem && nmc == q.mlast) begin
            n.st = ST_WRITE;
          end else begin
            n.st = ST_EXEC;
          end
        end
      end
    endcase
    n.mrd = (n.st == ST_READ);
  end

  // ==========================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q.st <= ST_IDLE;
      q.mc <= 3'h0;
      q.tc <= 3'h0;
      q.mlast <= 3'h0;
      q.tsum <= 5'h00;
      q.is_mem <= 1'b0;
      q.is_idx <= 1'b0;
      q.op <= OP_INC;
      q.dst <= 3'h0;
      q.opnd <= 8'h00;
      q.insn <= 24'h00_0000;
      q.gpr <= 64'h0;
      q.flg <= FLG_RST;
      q.ix1 <= IDX_RST;
      q.ix2 <= IDX_RST;
      q.illegal <= 1'b0;
      q.last_t <= 5'h00;
      q.last_m <= 3'h0;
      q.pready <= 1'b0;
      q.prdata <= 32'h0000_0000;
      q.pslverr <= 1'b0;
      q.maddr <= 16'h0000;
      q.mrd <= 1'b0;
      q.mwr <= 1'b0;
      q.mwdata <= 8'h00;
      q.done <= 1'b0;
    end else begin
      q <= n;
    end
  end

  // ==========================================
  // Outputs, each straight from the state register
  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign mem_addr = q.maddr;
  assign mem_rd = q.mrd;
  assign mem_wr = q.mwr;
  assign mem_wdata = q.mwdata;
  assign done = q.done;

endmodule : idalu_core
`default_nettype wire

// *** logic/idalu_pkg.sv ***
// Shared constants and types for the inc/dec/decimal-adjust slice
package idalu_pkg;

  // ==========================================
  // Register map (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_INSN = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_FLAG = 8'h0C;
  localparam logic [7:0] OFS_GPR = 8'h10;
  localparam logic [7:0] OFS_GPR_END = 8'h2C;
  localparam logic [7:0] OFS_IDX1 = 8'h30;
  localparam logic [7:0] OFS_IDX2 = 8'h34;

  // Control bits
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_CLR_ILL = 1;

  // Flag bit positions
  localparam int unsigned FLG_S = 7;
  localparam int unsigned FLG_Z = 6;
  localparam int unsigned FLG_H = 4;
  localparam int unsigned FLG_PV = 2;
  localparam int unsigned FLG_N = 1;
  localparam int unsigned FLG_C = 0;

  // ==========================================
  // Opcodes
  localparam logic [7:0] PFX_IDX1 = 8'hDD;
  localparam logic [7:0] PFX_IDX2 = 8'hFD;
  localparam logic [7:0] OPC_INC_MEM = 8'h34;
  localparam logic [7:0] OPC_DEC_MEM = 8'h35;
  localparam logic [7:0] OPC_DAA = 8'h27;
  localparam logic [2:0] FLD_MEM = 3'h6;
  localparam logic [2:0] FLD_ACC = 3'h7;
  localparam logic [2:0] FLD_H = 3'h4;
  localparam logic [2:0] FLD_L = 3'h5;

  // ==========================================
  // Timing: one T state is one pclk cycle
  localparam logic [2:0] REG_TS = 3'h4;
  localparam logic [5:0][2:0] IDX_TS = {3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
  localparam logic [2:0][2:0] PTR_TS = {3'h3, 3'h4, 3'h4};
  localparam logic [2:0] IDX_MLAST = 3'h5;
  localparam logic [2:0] PTR_MLAST = 3'h2;
  localparam logic [2:0] REG_MLAST = 3'h0;

  // Reset values
  localparam logic [7:0] FLG_RST = 8'h00;
  localparam logic [15:0] IDX_RST = 16'h0000;

  typedef enum logic [1:0] {
    OP_INC = 2'h0,
    OP_DEC = 2'h1,
    OP_DAA = 2'h2
  } idalu_op_e;

endpackage : idalu_pkg

// *** logic/idalu_unit.sv ***
// Combinational increment, decrement and decimal adjust with flags
`timescale 1ns/10ps
`default_nettype none
module idalu_unit (
  // Operand and result
  idalu_alu_if.unit alu
);
  import idalu_pkg::*;

  // ==========================================
  // Result and flag generation
  always_comb begin
    logic lo_fix;
    logic hi_fix;
    logic [7:0] corr;
    logic [7:0] a;
    a = alu.opnd;
    lo_fix = alu.flg_in[FLG_H] || (a[3:0] > 4'h9);
    hi_fix = alu.flg_in[FLG_C] || (a > 8'h99);
    corr = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
    alu.res = a;
    alu.flg_out = alu.flg_in;
    unique case (alu.op)
      OP_INC: begin
        alu.res = a + 8'h01;
        alu.flg_out[FLG_H] = (a[3:0] == 4'hF);
        alu.flg_out[FLG_PV] = (a == 8'h7F);
        alu.flg_out[FLG_N] = 1'b0;
      end
      OP_DEC: begin
        alu.res = a - 8'h01;
        alu.flg_out[FLG_H] = (a[3:0] == 4'h0);
        alu.flg_out[FLG_PV] = (a == 8'h80);
        alu.flg_out[FLG_N] = 1'b1;
      end
      OP_DAA: begin
        // Subtracting 06/60/66 equals adding FA/A0/9A
        if (alu.flg_in[FLG_N]) begin
          alu.res = a - corr;
          alu.flg_out[FLG_H] = alu.flg_in[FLG_H] && (a[3:0] < 4'h6);
        end else begin
          alu.res = a + corr;
          alu.flg_out[FLG_H] = (a[3:0] > 4'h9);
        end
        alu.flg_out[FLG_C] = hi_fix;
        alu.flg_out[FLG_PV] = ~^alu.res;
      end
      default: begin
        alu.res = a;
      end
    endcase
    // Sign and zero follow the result for every operation
    alu.flg_out[FLG_S] = alu.res[7];
    alu.flg_out[FLG_Z] = (alu.res == 8'h00);
  end

endmodule : idalu_unit
`default_nettype wire
